/* rtl/cfs_controller_fault_status.sv */
// Controller fault status register with its host read port
`timescale 1ns/1ps

// Summary of operation
// RQ1 - Bit 31 reads one whenever any fault flag of the register is set and zero otherwise.
// RQ2 - The register sits at host offset E2h, is read-only and reads 00000000h after reset.
// RQ3 - Bit 29 reads one while a pulse probe rate fault is detected, else zero.
// RQ4 - Bit 28 reads one while the first pulse probe timing fault is detected, else zero.
// RQ5 - Bit 27 reads one while the second pulse probe timing fault is detected, else zero.
// RQ6 - Bit 26 reads one while a supply bus current limit fault is present, else zero.
// RQ7 - Bit 25 reads one on a winding resistance or inductance measurement error, else zero.
// RQ8 - Bit 24 reads one on a back-EMF constant measurement error, else zero.
// RQ9 - Bit 23 reads one while an odd-speed lock condition is detected, else zero.
// RQ10 - Bit 22 reads one while an odd back-EMF lock condition is detected, else zero.
// RQ11 - Bit 21 reads one while the missing-motor condition is detected, else zero.
// RQ12 - Bit 20 reads one whenever any lock detection has triggered, else zero.
// RQ13 - Bits 19 and 18 flag the lock and hardware lock current-limit faults.
// RQ14 - Bits 17 and 16 flag motor supply undervoltage and overvoltage.
// RQ15 - Bits 15 and 14 flag speed loop and current loop saturation.
// RQ16 - Bit 30 and bits 13 to 0 read zero and host writes to the register are ignored.
module cfs_controller_fault_status (
	input  wire logic                       clk_sys,
	input  wire logic                       rst,
	input  wire cfs_pkg::cfs_flags_s        fault_in,
	input  wire cfs_pkg::cfs_host_req_s     host_req,
	output logic [cfs_pkg::DATA_W-1:0]      host_rd_data,
	output logic                            host_ack,
	output logic                            fault_summary
);

	// Stored fault fields, one cell each
	logic                           probe_rate_q;
	logic                           probe_first_q;
	logic                           probe_second_q;
	logic                           bus_cap_q;
	logic                           measure_rl_q;
	logic                           measure_backemf_q;
	logic                           odd_speed_q;
	logic                           odd_backemf_q;
	logic                           missing_motor_q;
	logic                           stall_any_q;
	logic                           stall_cap_q;
	logic                           hard_stall_cap_q;
	logic                           supply_low_q;
	logic                           supply_high_q;
	logic                           speed_sat_q;
	logic                           current_sat_q;

	logic                           summary_q;
	logic [cfs_pkg::DATA_W-1:0]     rd_data_q;
	logic                           ack_q;

	wire                            probe_any;
	wire                            measure_any;
	wire                            lock_any;
	wire                            supply_any;
	wire                            loop_any;
	wire                            summary_d;
	wire                            ack_d;
	wire                            hit;
	wire  [cfs_pkg::DATA_W-1:0]     reg_word;
	wire  [cfs_pkg::DATA_W-1:0]     rd_data_d;

	// Summary built from detector levels so it lands with the flags
	assign probe_any   = fault_in.pulse_probe_rate_error
		| fault_in.pulse_probe_first_timing_error
		| fault_in.pulse_probe_second_timing_error;
	assign measure_any = fault_in.param_measure_rl_error
		| fault_in.param_measure_backemf_error;
	assign lock_any    = fault_in.odd_speed_lock
		| fault_in.odd_backemf_lock
		| fault_in.missing_motor
		| fault_in.rotor_stall_any
		| fault_in.stall_current_cap
		| fault_in.hard_stall_current_cap;
	assign supply_any  = fault_in.bus_current_cap
		| fault_in.motor_supply_low
		| fault_in.motor_supply_high;
	assign loop_any    = fault_in.speed_loop_saturated
		| fault_in.current_loop_saturated;
	assign summary_d   = probe_any | measure_any | lock_any | supply_any | loop_any; // [RQ1]

	// Register word assembled field by field
	assign reg_word[cfs_pkg::SUMMARY_BIT]         = summary_q;          // [RQ1]
	assign reg_word[cfs_pkg::RSVD_HIGH_BIT]       = 1'b0;               // [RQ16]
	assign reg_word[cfs_pkg::POS_PROBE_RATE]      = probe_rate_q;       // [RQ3]
	assign reg_word[cfs_pkg::POS_PROBE_FIRST]     = probe_first_q;      // [RQ4]
	assign reg_word[cfs_pkg::POS_PROBE_SECOND]    = probe_second_q;     // [RQ5]
	assign reg_word[cfs_pkg::POS_BUS_CAP]         = bus_cap_q;          // [RQ6]
	assign reg_word[cfs_pkg::POS_MEASURE_RL]      = measure_rl_q;       // [RQ7]
	assign reg_word[cfs_pkg::POS_MEASURE_BACKEMF] = measure_backemf_q;  // [RQ8]
	assign reg_word[cfs_pkg::POS_ODD_SPEED]       = odd_speed_q;        // [RQ9]
	assign reg_word[cfs_pkg::POS_ODD_BACKEMF]     = odd_backemf_q;      // [RQ10]
	assign reg_word[cfs_pkg::POS_MISSING_MOTOR]   = missing_motor_q;    // [RQ11]
	assign reg_word[cfs_pkg::POS_STALL_ANY]       = stall_any_q;        // [RQ12]
	assign reg_word[cfs_pkg::POS_STALL_CAP]       = stall_cap_q;        // [RQ13]
	assign reg_word[cfs_pkg::POS_HARD_STALL_CAP]  = hard_stall_cap_q;   // [RQ13]
	assign reg_word[cfs_pkg::POS_SUPPLY_LOW]      = supply_low_q;       // [RQ14]
	assign reg_word[cfs_pkg::POS_SUPPLY_HIGH]     = supply_high_q;      // [RQ14]
	assign reg_word[cfs_pkg::POS_SPEED_SAT]       = speed_sat_q;        // [RQ15]
	assign reg_word[cfs_pkg::POS_CURRENT_SAT]     = current_sat_q;      // [RQ15]
	assign reg_word[cfs_pkg::FLAGS_LSB-1:0]       = '0;                 // [RQ16]

	// Only one offset decodes; any other address reads zero
	assign hit       = host_req.addr == cfs_pkg::CTRL_FAULT_FLAGS_OFS;  // [RQ2]
	assign rd_data_d = hit ? reg_word : cfs_pkg::UNMAPPED_READ_VAL;
	// Writes are acknowledged but never alter state
	assign ack_d     = host_req.rd_en | host_req.wr_en;                 // [RQ16]

	// Levels, not sticky: a cleared condition reads zero next cycle
	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.pulse_probe_rate_error)
	) u_probe_rate (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.pulse_probe_rate_error),              // [RQ3]
		.level_q (probe_rate_q)
	);

	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.pulse_probe_first_timing_error)
	) u_probe_first (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.pulse_probe_first_timing_error),      // [RQ4]
		.level_q (probe_first_q)
	);

	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.pulse_probe_second_timing_error)
	) u_probe_second (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.pulse_probe_second_timing_error),     // [RQ5]
		.level_q (probe_second_q)
	);

	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.bus_current_cap)
	) u_bus_cap (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.bus_current_cap),                     // [RQ6]
		.level_q (bus_cap_q)
	);

	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.param_measure_rl_error)
	) u_measure_rl (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.param_measure_rl_error),              // [RQ7]
		.level_q (measure_rl_q)
	);

	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.param_measure_backemf_error)
	) u_measure_backemf (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.param_measure_backemf_error),         // [RQ8]
		.level_q (measure_backemf_q)
	);

	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.odd_speed_lock)
	) u_odd_speed (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.odd_speed_lock),                      // [RQ9]
		.level_q (odd_speed_q)
	);

	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.odd_backemf_lock)
	) u_odd_backemf (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.odd_backemf_lock),                    // [RQ10]
		.level_q (odd_backemf_q)
	);

	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.missing_motor)
	) u_missing_motor (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.missing_motor),                       // [RQ11]
		.level_q (missing_motor_q)
	);

	// Own input, not derived from the other lock fields
	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.rotor_stall_any)
	) u_stall_any (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.rotor_stall_any),                     // [RQ12]
		.level_q (stall_any_q)
	);

	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.stall_current_cap)
	) u_stall_cap (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.stall_current_cap),                   // [RQ13]
		.level_q (stall_cap_q)
	);

	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.hard_stall_current_cap)
	) u_hard_stall_cap (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.hard_stall_current_cap),              // [RQ13]
		.level_q (hard_stall_cap_q)
	);

	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.motor_supply_low)
	) u_supply_low (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.motor_supply_low),                    // [RQ14]
		.level_q (supply_low_q)
	);

	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.motor_supply_high)
	) u_supply_high (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.motor_supply_high),                   // [RQ14]
		.level_q (supply_high_q)
	);

	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.speed_loop_saturated)
	) u_speed_sat (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.speed_loop_saturated),                // [RQ15]
		.level_q (speed_sat_q)
	);

	cfs_flag_cell #(
		.RST_VAL (cfs_pkg::FLAGS_RST.current_loop_saturated)
	) u_current_sat (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level_d (fault_in.current_loop_saturated),              // [RQ15]
		.level_q (current_sat_q)
	);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			summary_q <= 1'b0;                                   // [RQ2]
		end else begin
			summary_q <= summary_d;                              // [RQ1]
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_data_q <= cfs_pkg::CTRL_FAULT_FLAGS_RST;          // [RQ2]
			ack_q     <= 1'b0;
		end else begin
			ack_q <= ack_d;                                      // [RQ16]
			if (host_req.rd_en) begin
				rd_data_q <= rd_data_d;
			end
		end
	end

	assign host_rd_data  = rd_data_q;
	assign host_ack      = ack_q;
	assign fault_summary = summary_q;

endmodule // cfs_controller_fault_status

// One captured fault level with its own reset value
module cfs_flag_cell #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic level_d,
	output logic      level_q
);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			level_q <= RST_VAL;
		end else begin
			level_q <= level_d;
		end
	end

endmodule // cfs_flag_cell

/* rtl/cfs_pkg.sv */
// Package for the controller fault status register block
package cfs_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	localparam logic [ADDR_W-1:0] CTRL_FAULT_FLAGS_OFS = 8'hE2;
	localparam logic [DATA_W-1:0] CTRL_FAULT_FLAGS_RST = 32'h00000000;
	localparam logic [DATA_W-1:0] UNMAPPED_READ_VAL    = 32'h00000000;

	// Field positions inside the register word
	localparam int unsigned SUMMARY_BIT   = 31;
	localparam int unsigned RSVD_HIGH_BIT = 30;
	localparam int unsigned FLAGS_MSB     = 29;
	localparam int unsigned FLAGS_LSB     = 14;
	localparam int unsigned FLAGS_W       = FLAGS_MSB - FLAGS_LSB + 1;
	localparam int unsigned RSVD_LOW_W    = FLAGS_LSB;

	// Bit position of every fault field
	localparam int unsigned POS_PROBE_RATE      = 29;
	localparam int unsigned POS_PROBE_FIRST     = 28;
	localparam int unsigned POS_PROBE_SECOND    = 27;
	localparam int unsigned POS_BUS_CAP         = 26;
	localparam int unsigned POS_MEASURE_RL      = 25;
	localparam int unsigned POS_MEASURE_BACKEMF = 24;
	localparam int unsigned POS_ODD_SPEED       = 23;
	localparam int unsigned POS_ODD_BACKEMF     = 22;
	localparam int unsigned POS_MISSING_MOTOR   = 21;
	localparam int unsigned POS_STALL_ANY       = 20;
	localparam int unsigned POS_STALL_CAP       = 19;
	localparam int unsigned POS_HARD_STALL_CAP  = 18;
	localparam int unsigned POS_SUPPLY_LOW      = 17;
	localparam int unsigned POS_SUPPLY_HIGH     = 16;
	localparam int unsigned POS_SPEED_SAT       = 15;
	localparam int unsigned POS_CURRENT_SAT     = 14;

	// Field order follows the bit order, bit 29 first
	typedef struct packed {
		logic pulse_probe_rate_error;          // Bit 29
		logic pulse_probe_first_timing_error;  // Bit 28
		logic pulse_probe_second_timing_error; // Bit 27
		logic bus_current_cap;                 // Bit 26
		logic param_measure_rl_error;          // Bit 25
		logic param_measure_backemf_error;     // Bit 24
		logic odd_speed_lock;                  // Bit 23
		logic odd_backemf_lock;                // Bit 22
		logic missing_motor;                   // Bit 21
		logic rotor_stall_any;                 // Bit 20
		logic stall_current_cap;               // Bit 19
		logic hard_stall_current_cap;          // Bit 18
		logic motor_supply_low;                // Bit 17
		logic motor_supply_high;               // Bit 16
		logic speed_loop_saturated;            // Bit 15
		logic current_loop_saturated;          // Bit 14
	} cfs_flags_s;

	typedef struct packed {
		logic                rd_en;
		logic                wr_en;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wr_data;
	} cfs_host_req_s;

	localparam cfs_flags_s FLAGS_RST = '0;

endpackage

/* tb/cfs_checker.sv */
// Checker for the fault status register
`timescale 1ns/1ps
module cfs_checker (input wire logic clk_sys, rst, host_ack, fault_summary,
	input wire cfs_pkg::cfs_flags_s fault_in, input wire cfs_pkg::cfs_host_req_s host_req,
	input wire logic [cfs_pkg::DATA_W-1:0] host_rd_data);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire rd = host_req.rd_en, hit = host_req.addr == cfs_pkg::CTRL_FAULT_FLAGS_OFS;
	AST_ACK: assert property (host_ack == ($past(rd || host_req.wr_en) && !$past(rst)))
		else $error("ack");
	AST_SUM: assert property (fault_in != '0 |=> fault_summary) else $error("sum");
	AST_CLR: assert property (fault_in == '0 |=> !fault_summary) else $error("clr");
	AST_DATA: assert property (rd && hit && !$past(rst)
		|=> host_rd_data[29:14] == $past(fault_in, 2)) else $error("data");
	AST_RSV: assert property (!host_rd_data[30] && !host_rd_data[13:0]) else $error("rsv");
	AST_MAP: assert property (rd && !hit |=> host_rd_data == 32'h0) else $error("map");
	AST_HOLD: assert property (!rd |=> $stable(host_rd_data)) else $error("hold");
	AST_TOP: assert property (host_rd_data[31] == |host_rd_data[29:14]) else $error("top");
endmodule // cfs_checker
bind cfs_controller_fault_status cfs_checker u_chk (.*);

/* tb/cfs_controller_fault_status_tb.sv */
// Bench for the fault status register
`timescale 1ns/1ps
module cfs_controller_fault_status_tb;
	logic clk_sys = 1'h0, rst = 1'h1, host_ack, fault_summary;
	logic [31:0] host_rd_data;
	cfs_pkg::cfs_flags_s fault_in = '0;
	cfs_pkg::cfs_host_req_s host_req = '0;
	int error_cnt = 0, compares = 0;
	cfs_controller_fault_status uut (.*);
	initial forever #2.5 clk_sys = ~clk_sys;
	task chk(string name, logic [31:0] exp, logic [31:0] got);
		compares++;
		error_cnt += got !== exp;
		if (got !== exp) $display("unexpected %s exp %h got %h", name, exp, got);
	endtask
	task chk_bit(string name, logic exp, logic got);
		compares++;
		error_cnt += got !== exp;
		if (got !== exp) $display("unexpected %s exp %h got %h", name, exp, got);
	endtask
	task access(logic wr, logic [7:0] a, logic [31:0] exp);
		@(negedge clk_sys) host_req = '{!wr, wr, a, 32'hFFFFFFFF};
		@(negedge clk_sys) host_req = '0;
		chk("rd", exp, host_rd_data);
		chk_bit("ack", 1'h1, host_ack);
	endtask
	task t_both();
		fault_in = 16'hA5C3;
		@(negedge clk_sys) host_req = '{1'h1, 1'h1, 8'hE2, 32'h0};
		@(negedge clk_sys) host_req = '0;
		chk("both", {1'h1, 1'h0, 16'hA5C3, 14'h0}, host_rd_data);
		chk_bit("ack", 1'h1, host_ack);
	endtask
	task t_reset();
		@(negedge clk_sys) rst = 1'h1;
		@(negedge clk_sys) chk("rst", 32'h0, host_rd_data);
		chk_bit("rst_sum", 1'h0, fault_summary);
		rst = 1'h0;
		access(1'h0, 8'hE2, {1'h1, 1'h0, 16'hA5C3, 14'h0});
	endtask
	task t_flags();
		for (int i = 0; i < 18; i++) begin
			fault_in = 16'h1 << ((i + 16) % 17);
			access(1'h1, 8'hE2, 32'h0);
			access(1'h0, 8'hE2, {|fault_in, 1'h0, fault_in, 14'h0});
			access(1'h0, 8'hE3, 32'h0);
			chk_bit("sum", |fault_in, fault_summary);
		end
	endtask
	task finish_test();
		if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#80 rst = 1'h0;
		t_flags();
		t_both();
		t_reset();
		finish_test();
	end
	initial begin
		#2000 error_cnt++;
		finish_test();
	end
endmodule // cfs_controller_fault_status_tb
